/* File: core/bcl_debounce.sv */
// Debounces each short-circuit fault input.
// Assumes raw inputs already synchronised.
`timescale 1ns/10ps
module bcl_debounce
	import bcl_pkg::*;
#(
	parameter int N      = NUM_LDO,
	parameter int CYCLES = DEBOUNCE_CYCLES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Fault lines
	bcl_fault_if.deb  f
);
	localparam int CW = $clog2(CYCLES + 1);

	typedef struct packed {
		logic [N-1:0][CW-1:0]    cnt;
		logic [N-1:0]            stable;
		logic [N-1:0]            rise;
	} bcl_deb_s;

	bcl_deb_s st;
	bcl_deb_s next_st;

	always_comb begin
		next_st = st;
		next_st.rise = '0;
		for (int i = 0; i < N; i++) begin
			if (f.raw[i] == st.stable[i]) begin
				next_st.cnt[i] = '0;
			end else if (st.cnt[i] == CW'(CYCLES - 1)) begin
				next_st.cnt[i] = '0;
				next_st.stable[i] = f.raw[i];
				next_st.rise[i] = f.raw[i];
			end else begin
				next_st.cnt[i] = st.cnt[i] + CW'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign f.stable = st.stable;
	assign f.rise = st.rise;
endmodule

/* File: core/bcl_fault_if.sv */
// Carries debounced fault results between top and debouncer.
// Assumes the debouncer runs on the top's clock.
`timescale 1ns/10ps
interface bcl_fault_if #(parameter int N = 6);
	logic [N-1:0] raw;
	logic [N-1:0] stable;
	logic [N-1:0] rise;
	modport deb (input raw, output stable, output rise);
	modport top (output raw, input stable, input rise);
endinterface

/* File: core/bcl_pkg.sv */
// Constants for boost control and linear-regulator fault protection.
// Assumes an 8-bit register port and six linear regulators.
// Function
// - Boost sequenced only when slot nonzero
// - All boost control in one register
// - Bits 1:0 select 5.000-5.150 V output
// - Bits 3:2 run mode, read-only, 0x02
// - Bits 6:5 standby mode, writable, auto
// - Auto mode picks pulse mode by load
// - Sequenced boost starts in auto mode
// - Low-power bit forces lowest bias mode
// - Disabled regulator gets discharge pull-down
// - Pull-downs on while processor reset low
// - Debounce each short-circuit fault input
// - Short with protection clears enable, sets flag
// - Per-regulator mask suppresses fault interrupt
// - Protection off: no shutdown on short
// - Protection enable resets to cleared
// - Flag set regardless of protection enable
// - Enable bit at control bit 4
package bcl_pkg;
	localparam int NUM_LDO = 6;

	// ***************************************************
	// Register addresses
	// ***************************************************
	localparam logic [7:0] ADDR_BOOST_CTL  = 8'h66;
	localparam logic [7:0] ADDR_LDO_CTL0   = 8'h6c;
	localparam logic [7:0] ADDR_FAULT_FLAG = 8'h40;
	localparam logic [7:0] ADDR_FAULT_MASK = 8'h41;
	localparam logic [7:0] ADDR_PROT_CTL   = 8'h42;

	// ***************************************************
	// Field positions and resets
	// ***************************************************
	localparam int BOOST_VOLT_LSB  = 0;
	localparam int BOOST_RUN_LSB   = 2;
	localparam int BOOST_STBY_LSB  = 5;
	localparam int LDO_VOLT_LSB    = 0;
	localparam int LDO_EN_BIT      = 4;
	localparam int LDO_STBY_BIT    = 5;
	localparam int LDO_LPWR_BIT    = 6;
	localparam int PROT_EN_BIT     = 0;
	localparam logic [1:0] BOOST_VOLT_RST = 2'h0;
	localparam logic [1:0] BOOST_MODE_RST = 2'h2;
	localparam logic [3:0] LDO_VOLT_RST   = 4'h0;
	localparam logic [5:0] MASK_RST       = 6'h3f;

	// ***************************************************
	// Timing
	// ***************************************************
	localparam int CLK_MHZ         = 100;
	localparam int DEBOUNCE_US     = 8;
	localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
	localparam int DEB_W           = $clog2(DEBOUNCE_CYCLES + 1);

	typedef enum logic [1:0] {
		MODE_OFF,
		MODE_PFM,
		MODE_AUTO,
		MODE_SKIP
	} bcl_mode_e;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_WAIT,
		SEQ_ON
	} bcl_seq_e;
endpackage

/* File: core/bcl_top.sv */
// Boost control register and linear-regulator short protection.
// Assumes a simple 8-bit register port from the serial control block.
`timescale 1ns/10ps
module bcl_top
	import bcl_pkg::*;
#(
	parameter int N          = NUM_LDO,
	parameter int DEB_CYCLES = DEBOUNCE_CYCLES
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// Register port
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	output logic      [7:0]        reg_rdata,
	// Sequencing and state
	input  wire logic [4:0]        boost_seq_slot,
	input  wire logic              seq_start,
	input  wire logic              standby,
	input  wire logic              processor_reset_n,
	input  wire logic              boost_heavy_load,
	// Fault inputs from regulators
	input  wire logic [N-1:0]      ldo_short,
	// Regulator controls
	output logic                   boost_enable,
	output logic      [1:0]        boost_volt_sel,
	output logic      [1:0]        boost_active_mode,
	output logic                   boost_pfm_active,
	output logic      [N-1:0]      ldo_on,
	output logic      [N-1:0]      ldo_force_lowpower,
	output logic      [N-1:0]      ldo_discharge,
	output logic                   fault_irq
);
	import bcl_pkg::*;

	typedef struct packed {
		logic [N-1:0][1:0]  sync;
		logic [1:0]         rst_sync;
		logic [1:0]         load_sync;
		logic [1:0]         stby_sync;
		logic [1:0]         volt;
		logic [1:0]         run_mode;
		logic [1:0]         stby_mode;
		bcl_seq_e           seq;
		logic [N-1:0][3:0]  ldo_volt;
		logic [N-1:0]       ldo_enable_bit;
		logic [N-1:0]       ldo_stby;
		logic [N-1:0]       ldo_lpwr;
		logic [N-1:0]       ldo_fault_flag;
		logic [N-1:0]       ldo_fault_mask;
		logic               short_prot_enable;
		logic [7:0]         rdata;
		logic               b_en;
		logic [1:0]         b_volt;
		logic [1:0]         b_mode;
		logic               b_pfm;
		logic [N-1:0]       l_on;
		logic [N-1:0]       l_lp;
		logic [N-1:0]       l_dis;
		logic               irq;
	} bcl_top_s;

	bcl_top_s st;
	bcl_top_s next_st;

	bcl_fault_if #(.N(N)) flt ();

	bcl_debounce #(.N(N), .CYCLES(DEB_CYCLES)) u_deb (
		.clk  (clk),
		.nrst (nrst),
		.f    (flt)
	);

	// ***************************************************
	// Helpers
	// ***************************************************
	function automatic logic is_ldo(input logic [7:0] a);
		return (a >= ADDR_LDO_CTL0) && (a < ADDR_LDO_CTL0 + 8'(N));
	endfunction

	function automatic logic [2:0] ldo_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - ADDR_LDO_CTL0;
		return d[2:0];
	endfunction

	always_comb begin
		flt.raw = '0;
		for (int i = 0; i < N; i++) begin
			flt.raw[i] = st.sync[i][1];
		end
	end

	// ***************************************************
	// Next state
	// ***************************************************
	always_comb begin
		logic [1:0] mode;
		mode = 2'h0;
		next_st = st;
		for (int i = 0; i < N; i++) begin
			next_st.sync[i] = {st.sync[i][0], ldo_short[i]};
		end
		next_st.rst_sync = {st.rst_sync[0], processor_reset_n};
		next_st.load_sync = {st.load_sync[0], boost_heavy_load};
		next_st.stby_sync = {st.stby_sync[0], standby};

		// Register writes
		if (reg_wr) begin
			if (reg_addr == ADDR_BOOST_CTL) begin
				next_st.volt = reg_wdata[BOOST_VOLT_LSB +: 2];
				next_st.stby_mode = reg_wdata[BOOST_STBY_LSB +: 2];
			end else if (is_ldo(reg_addr)) begin
				next_st.ldo_volt[ldo_idx(reg_addr)] = reg_wdata[LDO_VOLT_LSB +: 4];
				next_st.ldo_enable_bit[ldo_idx(reg_addr)] = reg_wdata[LDO_EN_BIT];
				next_st.ldo_stby[ldo_idx(reg_addr)] = reg_wdata[LDO_STBY_BIT];
				next_st.ldo_lpwr[ldo_idx(reg_addr)] = reg_wdata[LDO_LPWR_BIT];
			end else if (reg_addr == ADDR_FAULT_FLAG) begin
				next_st.ldo_fault_flag = st.ldo_fault_flag & ~reg_wdata[N-1:0];
			end else if (reg_addr == ADDR_FAULT_MASK) begin
				next_st.ldo_fault_mask = reg_wdata[N-1:0];
			end else if (reg_addr == ADDR_PROT_CTL) begin
				next_st.short_prot_enable = reg_wdata[PROT_EN_BIT];
			end
		end

		// Fault handling, wins over same-cycle writes
		for (int i = 0; i < N; i++) begin
			if (flt.rise[i]) begin
				next_st.ldo_fault_flag[i] = 1'b1;
				if (st.short_prot_enable) begin
					next_st.ldo_enable_bit[i] = 1'b0;
				end
			end
		end

		// Boost sequencing
		case (st.seq)
			SEQ_IDLE: begin
				if (seq_start && boost_seq_slot != 5'h0) begin
					next_st.seq = SEQ_ON;
					next_st.run_mode = BOOST_MODE_RST;
				end
			end
			SEQ_WAIT: begin
				next_st.seq = SEQ_ON;
			end
			SEQ_ON: begin
				next_st.seq = SEQ_ON;
			end
			default: begin
				next_st.seq = SEQ_IDLE;
			end
		endcase

		// Boost outputs
		mode = st.stby_sync[1] ? st.stby_mode : st.run_mode;
		next_st.b_en = (st.seq == SEQ_ON) && (mode != 2'(MODE_OFF));
		next_st.b_volt = st.volt;
		next_st.b_mode = mode;
		if (mode == 2'(MODE_AUTO)) begin
			next_st.b_pfm = !st.load_sync[1];
		end else begin
			next_st.b_pfm = (mode == 2'(MODE_PFM));
		end

		// Linear regulator outputs
		for (int i = 0; i < N; i++) begin
			next_st.l_on[i] = st.ldo_enable_bit[i] && !(st.stby_sync[1] && st.ldo_stby[i] && !st.ldo_lpwr[i]);
			next_st.l_lp[i] = st.ldo_enable_bit[i] && st.ldo_lpwr[i];
			next_st.l_dis[i] = !next_st.l_on[i] || !st.rst_sync[1];
		end
		next_st.irq = |(st.ldo_fault_flag & ~st.ldo_fault_mask);

		// Read data
		next_st.rdata = 8'h0;
		if (reg_rd) begin
			if (reg_addr == ADDR_BOOST_CTL) begin
				next_st.rdata = {1'b0, st.stby_mode, 1'b0, st.run_mode, st.volt};
			end else if (is_ldo(reg_addr)) begin
				next_st.rdata = {1'b0, st.ldo_lpwr[ldo_idx(reg_addr)], st.ldo_stby[ldo_idx(reg_addr)],
					st.ldo_enable_bit[ldo_idx(reg_addr)], st.ldo_volt[ldo_idx(reg_addr)]};
			end else if (reg_addr == ADDR_FAULT_FLAG) begin
				next_st.rdata = 8'(st.ldo_fault_flag);
			end else if (reg_addr == ADDR_FAULT_MASK) begin
				next_st.rdata = 8'(st.ldo_fault_mask);
			end else if (reg_addr == ADDR_PROT_CTL) begin
				next_st.rdata = {7'h0, st.short_prot_enable};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st <= '0;
			st.run_mode <= BOOST_MODE_RST;
			st.stby_mode <= BOOST_MODE_RST;
			st.volt <= BOOST_VOLT_RST;
			st.ldo_fault_mask <= MASK_RST[N-1:0];
			st.short_prot_enable <= 1'b0;
			st.seq <= SEQ_IDLE;
			st.l_dis <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign boost_enable = st.b_en;
	assign boost_volt_sel = st.b_volt;
	assign boost_active_mode = st.b_mode;
	assign boost_pfm_active = st.b_pfm;
	assign ldo_on = st.l_on;
	assign ldo_force_lowpower = st.l_lp;
	assign ldo_discharge = st.l_dis;
	assign fault_irq = st.irq;
endmodule

/* File: tb/bcl_assertions.sv */
// Port checker for bcl_top.
// Assumes binding onto bcl_top, one clock.
`timescale 1ns/10ps
module bcl_assertions #(parameter int N = 6) (
	// Clock and reset
	input wire logic         clk,
	input wire logic         nrst,
	// Register port
	input wire logic         reg_wr,
	input wire logic         reg_rd,
	input wire logic [7:0]   reg_addr,
	input wire logic [7:0]   reg_wdata,
	input wire logic [7:0]   reg_rdata,
	// State inputs
	input wire logic [4:0]   boost_seq_slot,
	input wire logic         standby,
	input wire logic         processor_reset_n,
	input wire logic         boost_heavy_load,
	// Outputs
	input wire logic         boost_enable,
	input wire logic [1:0]   boost_volt_sel,
	input wire logic [1:0]   boost_active_mode,
	input wire logic         boost_pfm_active,
	input wire logic [N-1:0] ldo_on,
	input wire logic [N-1:0] ldo_force_lowpower,
	input wire logic [N-1:0] ldo_discharge,
	input wire logic         fault_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	off_discharge_a: assert property ((~ldo_on & ~ldo_discharge) == '0)
		else $error("off regulator not discharged");
	rst_discharge_a: assert property (!processor_reset_n [*4] |=> &ldo_discharge)
		else $error("no discharge in processor reset");
	lowpower_on_a: assert property ((ldo_force_lowpower & ~ldo_on) == '0)
		else $error("low power on off regulator");
	volt_write_a: assert property (reg_wr && reg_addr == 8'h66 |=> ##1 boost_volt_sel == $past(reg_wdata[1:0], 2))
		else $error("voltage select not written");
	run_mode_ro_a: assert property (reg_rd && reg_addr == 8'h66 |=> reg_rdata[3:2] == 2'h2 && !reg_rdata[4])
		else $error("run mode not fixed");
	seq_slot_a: assert property ($rose(boost_enable) |-> boost_seq_slot != 5'h00)
		else $error("boost started with empty slot");
	auto_start_a: assert property ($rose(boost_enable) && !standby |-> boost_active_mode == 2'h2)
		else $error("boost not started in auto");
	auto_pfm_a: assert property ((boost_active_mode == 2'h2 && $stable(boost_heavy_load)) [*4]
		|-> boost_pfm_active == !boost_heavy_load)
		else $error("auto mode ignores load");
	irq_sticky_a: assert property ($fell(fault_irq) |-> $past(reg_wr) || $past(reg_wr, 2))
		else $error("fault irq dropped by itself");
endmodule

/* File: tb/bcl_host.sv */
// Processor model: register reads and writes.
// Assumes bcl_top register port timing.
`timescale 1ns/10ps
module bcl_host (
	// Clock
	input wire logic       clk,
	// Register port
	output logic           reg_wr = 1'b0,
	output logic           reg_rd = 1'b0,
	output logic     [7:0] reg_addr = 8'h00,
	output logic     [7:0] reg_wdata = 8'h00,
	input wire logic [7:0] reg_rdata
);
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for bcl_top.
// Assumes short debounce count in simulation.
`timescale 1ns/10ps
module tb_top;
	import bcl_pkg::*;
	localparam int N = NUM_LDO;
	logic clk = 0, nrst = 0, reg_wr, reg_rd, seq_start = 0, standby = 0;
	logic processor_reset_n = 1, boost_heavy_load = 0, boost_enable, boost_pfm_active, fault_irq;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [4:0] boost_seq_slot = 0;
	logic [1:0] boost_volt_sel, boost_active_mode;
	logic [N-1:0] ldo_short = 0, ldo_on, ldo_force_lowpower, ldo_discharge;
	int bad_count = 0, total_checks = 0;
	always #5 clk = ~clk;
	bcl_host bcl_host_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	bcl_top #(.DEB_CYCLES(4)) bcl_top_inst (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .boost_seq_slot(boost_seq_slot),
		.seq_start(seq_start), .standby(standby), .processor_reset_n(processor_reset_n),
		.boost_heavy_load(boost_heavy_load), .ldo_short(ldo_short), .boost_enable(boost_enable),
		.boost_volt_sel(boost_volt_sel), .boost_active_mode(boost_active_mode),
		.boost_pfm_active(boost_pfm_active), .ldo_on(ldo_on), .ldo_force_lowpower(ldo_force_lowpower),
		.ldo_discharge(ldo_discharge), .fault_irq(fault_irq));
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bound_chk(int i, int lim);
		if (i >= lim) begin
			bad_count++;
			results();
		end
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_regs;
		logic [7:0] d;
		bcl_host_inst.rd(8'h66, d);
		chk("bst_rst", d, 8'h48);
		bcl_host_inst.rd(8'h42, d);
		chk("prot_rst", d, 8'h00);
		bcl_host_inst.rd(8'h07, d);
		chk("unmapped", d, 8'h00);
		for (int v = 0; v < 4; v++) begin
			bcl_host_inst.wr(8'h66, 8'h9c | 8'(v * 33));
			cyc(2);
			chk("volt", {6'h0, boost_volt_sel}, 8'(v));
			bcl_host_inst.rd(8'h66, d);
			chk("bst_ctl", d, 8'(v * 33) | 8'h08);
		end
	endtask
	task automatic t_seq;
		int i;
		@(posedge clk) seq_start <= 1'b1;
		@(posedge clk) seq_start <= 1'b0;
		cyc(10);
		chk("slot0", {7'h0, boost_enable}, 8'h00);
		@(posedge clk) nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		boost_seq_slot <= 5'h03;
		seq_start <= 1'b1;
		@(posedge clk) seq_start <= 1'b0;
		for (i = 0; i < 20 && boost_enable !== 1'b1; i++) cyc(1);
		bound_chk(i, 20);
		chk("auto_start", {6'h0, boost_active_mode}, 8'h02);
		@(posedge clk) boost_heavy_load <= 1'b1;
		cyc(6);
		chk("pfm_heavy", {7'h0, boost_pfm_active}, 8'h00);
		@(posedge clk) boost_heavy_load <= 1'b0;
		cyc(6);
		chk("pfm_light", {7'h0, boost_pfm_active}, 8'h01);
		bcl_host_inst.wr(8'h66, 8'h60);
		@(posedge clk) standby <= 1'b1;
		cyc(6);
		chk("stby_mode", {6'h0, boost_active_mode}, 8'h03);
		chk("skip_pfm", {7'h0, boost_pfm_active}, 8'h00);
		bcl_host_inst.wr(8'h66, 8'h20);
		cyc(3);
		chk("stby_pfm", {5'h0, boost_active_mode, boost_pfm_active}, 8'h03);
		bcl_host_inst.wr(8'h66, 8'h00);
		cyc(3);
		chk("stby_off", {7'h0, boost_enable}, 8'h00);
		@(posedge clk) standby <= 1'b0;
		cyc(6);
		chk("run_auto", {5'h0, boost_active_mode, boost_enable}, 8'h05);
	endtask
	task automatic t_fault;
		logic [7:0] d;
		int i;
		bcl_host_inst.wr(8'h6c, 8'h50);
		cyc(3);
		chk("ldo_on", {7'h0, ldo_on[0]}, 8'h01);
		chk("lpwr", {7'h0, ldo_force_lowpower[0]}, 8'h01);
		@(posedge clk) ldo_short[0] <= 1'b1;
		cyc(20);
		chk("noprot_on", {7'h0, ldo_on[0]}, 8'h01);
		chk("masked", {7'h0, fault_irq}, 8'h00);
		bcl_host_inst.rd(8'h40, d);
		chk("flag", d, 8'h01);
		bcl_host_inst.wr(8'h41, 8'h3e);
		@(posedge clk) ldo_short[0] <= 1'b0;
		cyc(20);
		chk("sticky", {7'h0, fault_irq}, 8'h01);
		bcl_host_inst.wr(8'h40, 8'h01);
		bcl_host_inst.wr(8'h42, 8'h01);
		cyc(3);
		chk("cleared", {7'h0, fault_irq}, 8'h00);
		@(posedge clk) ldo_short[0] <= 1'b1;
		repeat (2) @(posedge clk);
		ldo_short[0] <= 1'b0;
		cyc(20);
		chk("glitch", {7'h0, fault_irq}, 8'h00);
		@(posedge clk) ldo_short[0] <= 1'b1;
		for (i = 0; i < 40 && ldo_on[0] !== 1'b0; i++) cyc(1);
		bound_chk(i, 40);
		cyc(2);
		chk("prot_irq", {7'h0, fault_irq}, 8'h01);
		chk("prot_dis", {7'h0, ldo_discharge[0]}, 8'h01);
		bcl_host_inst.rd(8'h6c, d);
		chk("en_clr", d, 8'h40);
		@(posedge clk) ldo_short[0] <= 1'b0;
		bcl_host_inst.wr(8'h6d, 8'h10);
		@(posedge clk) processor_reset_n <= 1'b0;
		cyc(6);
		chk("prst_dis", {2'h0, ldo_discharge}, 8'h3f);
		@(posedge clk) processor_reset_n <= 1'b1;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_seq();
		t_fault();
		cyc(8);
		results();
	end
endmodule
bind bcl_top bcl_assertions #(.N(N)) bcl_assertions_inst (.clk(clk), .nrst(nrst), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.boost_seq_slot(boost_seq_slot), .standby(standby), .processor_reset_n(processor_reset_n),
	.boost_heavy_load(boost_heavy_load), .boost_enable(boost_enable), .boost_volt_sel(boost_volt_sel),
	.boost_active_mode(boost_active_mode), .boost_pfm_active(boost_pfm_active), .ldo_on(ldo_on),
	.ldo_force_lowpower(ldo_force_lowpower), .ldo_discharge(ldo_discharge), .fault_irq(fault_irq));
